/* File: csri_pkg.sv */
// ============================================================
// Shared constants of the charger register interface
// ============================================================
package csri_pkg;

  // ==========================================================
  // Bus addressing and command codes
  // ==========================================================
  localparam logic [6:0] SLAVE_ADDR  = 7'h09;  // Eight-bit form is 0x12
  localparam logic [7:0] CMD_MODE    = 8'h12;  // Operating modes
  localparam logic [7:0] CMD_STATUS  = 8'h13;  // Operating status, read only
  localparam logic [7:0] CMD_CURR    = 8'h14;  // Charge current limit
  localparam logic [7:0] CMD_VOLT    = 8'h15;  // Charge voltage limit
  localparam logic [7:0] CMD_INCURR  = 8'h3F;  // Input current limit

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_BAT_SYS  = 6;   // Status: battery feeds system
  localparam int BIT_ADP_SYS  = 7;   // Status: adapter feeds system
  localparam int BIT_VRANGE   = 4;   // Status: voltage range fault
  localparam int BIT_LEARN    = 6;   // Mode: discharge calibration
  localparam int DEP_LSB      = 9;   // Mode: depleted threshold low bit
  localparam int DEP_MSB      = 11;  // Mode: depleted threshold high bit
  localparam int PIN_SCL      = 0;   // Sync slot of bus clock
  localparam int PIN_SDA      = 1;   // Sync slot of bus data
  localparam int PIN_ADP      = 2;   // Sync slot of adapter detect
  localparam int NUM_PINS     = 3;   // Synchronised pins
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;  // Bits per bus byte

  // ==========================================================
  // Charge voltage windows in millivolts
  // ==========================================================
  localparam logic [15:0] V_PRECHG = 16'h2328;  // 9000 mV
  localparam logic [15:0] V_3C_LO  = 16'h2EE0;  // 12000 mV
  localparam logic [15:0] V_3C_HI  = 16'h3840;  // 14400 mV
  localparam logic [15:0] V_4C_LO  = 16'h3E80;  // 16000 mV

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic [15:0] RST_WORD   = 16'h0000;  // Limits and modes
  localparam logic [15:0] RST_STATUS = 16'h0040;  // Battery on system
  localparam logic [7:0]  RST_BYTE   = 8'h00;     // Shift and command
  localparam logic [3:0]  RST_CNT    = 4'h0;      // Bit counter

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_CMD   = 3'b011,
    ST_WDATA = 3'b100,
    ST_TX    = 3'b101,
    ST_RXACK = 3'b110
  } csri_state_t;

endpackage

/* File: csri_pin_if.sv */
`timescale 1ns/10ps
// ============================================================
// Clean pin levels and events from synchroniser to core
// ============================================================
interface csri_pin_if;
  logic scl;       // Stable bus clock level
  logic sda;       // Stable bus data level
  logic adp;       // Stable adapter detect level
  logic scl_rise;  // Bus clock rose
  logic scl_fall;  // Bus clock fell
  logic start;     // Start or repeated start seen
  logic stop;      // Stop seen
  modport src (output scl, sda, adp, scl_rise, scl_fall, start, stop);
  modport snk (input  scl, sda, adp, scl_rise, scl_fall, start, stop);
endinterface

/* File: csri_pin_sync.sv */
`timescale 1ns/10ps
// ============================================================
// Three-stage pin synchroniser with edge and frame detection
// ============================================================
module csri_pin_sync
  import csri_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_adapter_det,
  csri_pin_if.src   pins
);

  // All state of the synchroniser
  typedef struct packed {
    logic [NUM_PINS-1:0] ff1;  // First stage, read by second only
    logic [NUM_PINS-1:0] ff2;  // Second stage
    logic [NUM_PINS-1:0] ff3;  // Third stage
    logic [NUM_PINS-1:0] lvl;  // Accepted level
    logic                rise; // Bus clock rose
    logic                fall; // Bus clock fell
    logic                sta;  // Start condition
    logic                sto;  // Stop condition
  } csri_sync_t;

  csri_sync_t s;       // Registered state
  csri_sync_t next_s;  // Next state

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_s     = s;
    next_s.ff1 = {i_adapter_det, i_sda, i_scl};
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    // Accept a level once second and third stages agree
    next_s.lvl  = (s.ff2 & s.ff3) | (s.lvl & (s.ff2 ^ s.ff3));
    next_s.rise = ~s.lvl[PIN_SCL] & next_s.lvl[PIN_SCL];
    next_s.fall = s.lvl[PIN_SCL] & ~next_s.lvl[PIN_SCL];
    // Data moves while clock stays high
    next_s.sta  = s.lvl[PIN_SCL] & next_s.lvl[PIN_SCL]
                & s.lvl[PIN_SDA] & ~next_s.lvl[PIN_SDA];
    next_s.sto  = s.lvl[PIN_SCL] & next_s.lvl[PIN_SCL]
                & ~s.lvl[PIN_SDA] & next_s.lvl[PIN_SDA];
  end

  // Idle bus high and adapter detect level low after reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{ff1: 3'h3, ff2: 3'h3, ff3: 3'h3, lvl: 3'h3,
             rise: 1'b0, fall: 1'b0, sta: 1'b0, sto: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Outputs to the core
  assign pins.scl      = s.lvl[PIN_SCL];
  assign pins.sda      = s.lvl[PIN_SDA];
  assign pins.adp      = s.lvl[PIN_ADP];
  assign pins.scl_rise = s.rise;
  assign pins.scl_fall = s.fall;
  assign pins.start    = s.sta;
  assign pins.stop     = s.sto;

endmodule // csri_pin_sync

/* File: csri_charger_regs.sv */
`timescale 1ns/10ps
// ============================================================
// Charger bus slave, register bank, alert and source selector
// ============================================================
// Function
// - Full bus protocol, no packet error check
// - Answer only at address 0x12
// - Five sixteen-bit registers, nothing else
// - Command 0x15 sets charge voltage
// - Command 0x14 sets charge current
// - Command 0x3F sets input current limit
// - Command 0x12 sets modes, calibration
// - Command 0x13 reads operating status
// - Status change pulls alert low
// - Alert holds until status read completes
// - Charging unaffected by unread status
// - No watchdog, settings persist forever
// - Adapter feeds system when present, outside calibration
// - Calibration mode puts battery on system
// - Status bits 6,7 show battery, adapter source
// - Mode bits 9-11 select depleted threshold
// - Charge voltage zero after reset
// - Bad voltage disables, flags, alerts
module csri_charger_regs
  import csri_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic        i_alert,
  output logic             o_alert,
  output logic             o_alert_oe_n,
  input  wire logic        i_adapter_det,
  output logic [15:0]      o_charge_voltage_limit,
  output logic [15:0]      o_charge_current_limit,
  output logic [15:0]      o_input_current_limit,
  output logic [15:0]      o_mode_control,
  output logic [2:0]       o_depleted_pack_threshold,
  output logic             o_charge_en,
  output logic             o_adapter_to_sys,
  output logic             o_battery_to_sys
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    csri_state_t st;        // Bus engine state
    csri_state_t aft;       // State after acknowledge
    logic [7:0]  sh;        // Receive shift register
    logic [3:0]  cnt;       // Bit counter
    logic        rw;        // Read direction
    logic [7:0]  cmd;       // Selected command code
    logic [7:0]  lo;        // Held low byte of a write
    logic [1:0]  bidx;      // Data byte index
    logic [15:0] tx;        // Word snapshot for reads
    logic        sda_oe_n;  // Data pin enable, low drives
    logic        alert_oe_n;// Alert pin enable, low drives
    logic [15:0] mode;      // mode_control
    logic [15:0] ccur;      // charge_current_limit
    logic [15:0] cvolt;     // charge_voltage_limit
    logic [15:0] icur;      // input_current_limit
    logic [15:0] status;    // operating_status
    logic        chg_en;    // Charger enabled
    logic        adp_sys;   // Adapter switched to system
    logic        bat_sys;   // Battery switched to system
  } csri_core_t;

  csri_core_t s;        // Registered state
  csri_core_t next_s;   // Next state
  csri_pin_if pins ();  // Clean pin view
  logic       wr_commit;// Full write word taken
  logic       rd_clr;   // Status read completed
  logic       stat_chg; // Status content changed
  logic       v_bad;    // Programmed voltage out of range
  logic [15:0] wword;   // Word being written

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  csri_pin_sync u_sync (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_scl         (i_scl),
    .i_sda         (i_sda),
    .i_adapter_det (i_adapter_det),
    .pins          (pins.src)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  // Only these codes are mapped
  function automatic logic mapped(input logic [7:0] c);
    mapped = (c == CMD_MODE) || (c == CMD_STATUS) || (c == CMD_CURR)
          || (c == CMD_VOLT) || (c == CMD_INCURR);
  endfunction

  // Voltage check on bits 1 to 14; anything from the top window up passes
  function automatic logic volt_bad(input logic [15:0] v);
    logic [15:0] m;
    m = {1'b0, v[14:1], 1'b0};
    volt_bad = (m != RST_WORD) && !((m == V_PRECHG)
            || ((m >= V_3C_LO) && (m <= V_3C_HI)) || (m >= V_4C_LO));
  endfunction

  // Read multiplexer
  function automatic logic [15:0] rd_word(input csri_core_t q);
    unique case (q.cmd)
      CMD_MODE:   rd_word = q.mode;
      CMD_STATUS: rd_word = q.status;
      CMD_CURR:   rd_word = q.ccur;
      CMD_VOLT:   rd_word = q.cvolt;
      CMD_INCURR: rd_word = q.icur;
      default:    rd_word = RST_WORD;
    endcase
  endfunction

  // Bit to send, most significant first
  function automatic logic tx_bit(input logic [15:0] w, input logic hi,
                                  input logic [2:0] k);
    tx_bit = w[{hi, 3'h7 - k}];
  endfunction

  assign v_bad = volt_bad(s.cvolt);
  assign wword = {s.sh, s.lo};

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_s    = s;
    wr_commit = 1'b0;
    rd_clr    = 1'b0;
    // Stop or start resets the engine anywhere; no check byte
    if (pins.stop) begin
      next_s.st       = ST_IDLE;
      next_s.sda_oe_n = 1'b1;
    end else if (pins.start) begin
      next_s.st       = ST_ADDR;
      next_s.cnt      = RST_CNT;
      next_s.sda_oe_n = 1'b1;
    end else begin
      unique case (s.st)
        // Waiting for a start
        ST_IDLE: begin
        end
        // Receiving a byte
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (pins.scl_rise) begin
            next_s.sh  = {s.sh[6:0], pins.sda};
            next_s.cnt = s.cnt + 4'h1;
          end else if (pins.scl_fall && (s.cnt == BITS_PER_BYTE)) begin
            next_s.cnt      = RST_CNT;
            next_s.st       = ST_ACK;
            next_s.sda_oe_n = 1'b0;
            if (s.st == ST_ADDR) begin
              next_s.rw   = s.sh[0];
              next_s.bidx = 2'h0;
              next_s.tx   = rd_word(s);
              next_s.aft  = s.sh[0] ? ST_TX : ST_CMD;
              if (s.sh[7:1] != SLAVE_ADDR) begin
                next_s.st       = ST_IDLE;
                next_s.sda_oe_n = 1'b1;
              end
            end else if (s.st == ST_CMD) begin
              next_s.cmd = s.sh;
              next_s.aft = ST_WDATA;
              if (!mapped(s.sh)) begin
                next_s.st       = ST_IDLE;
                next_s.sda_oe_n = 1'b1;
              end
            end else if (s.bidx == 2'h0) begin
              // Low byte comes first and is held
              next_s.lo   = s.sh;
              next_s.bidx = 2'h1;
              next_s.aft  = ST_WDATA;
            end else if (s.bidx == 2'h1) begin
              wr_commit   = 1'b1;
              next_s.bidx = 2'h2;
              next_s.aft  = ST_WDATA;
            end else begin
              // Bytes past the word are refused
              next_s.st       = ST_IDLE;
              next_s.sda_oe_n = 1'b1;
            end
          end
        end
        // Acknowledge bit held until the falling clock
        ST_ACK: begin
          if (pins.scl_fall) begin
            next_s.st = s.aft;
            if (s.aft == ST_TX) begin
              next_s.sda_oe_n = tx_bit(s.tx, s.bidx[0], 3'h0);
              next_s.cnt      = 4'h1;
            end else begin
              next_s.sda_oe_n = 1'b1;
            end
          end
        end
        // Sending a byte
        ST_TX: begin
          if (pins.scl_fall) begin
            if (s.cnt == BITS_PER_BYTE) begin
              next_s.sda_oe_n = 1'b1;
              next_s.st       = ST_RXACK;
            end else begin
              next_s.sda_oe_n = tx_bit(s.tx, s.bidx[0], s.cnt[2:0]);
              next_s.cnt      = s.cnt + 4'h1;
            end
          end
        end
        // Master answer after a sent byte
        ST_RXACK: begin
          if (pins.scl_rise) begin
            if (s.bidx == 2'h1) begin
              // A change after the snapshot keeps the alert up
              rd_clr    = (s.cmd == CMD_STATUS) && (s.tx == s.status);
              next_s.st = ST_IDLE;
            end else if (pins.sda) begin
              next_s.st = ST_IDLE;
            end else begin
              next_s.bidx = 2'h1;
              next_s.aft  = ST_TX;
              next_s.st   = ST_ACK;
            end
          end
        end
        default: begin
          next_s.st       = ST_IDLE;
          next_s.sda_oe_n = 1'b1;
        end
      endcase
    end

    // Word lands in one cycle; status ignores writes
    if (wr_commit) begin
      unique case (s.cmd)
        CMD_VOLT:   next_s.cvolt = wword;
        CMD_CURR:   next_s.ccur  = wword;
        CMD_INCURR: next_s.icur  = wword;
        CMD_MODE:   next_s.mode  = wword;
        default: begin
        end
      endcase
    end

    // Source selector; calibration overrides the adapter
    next_s.adp_sys = pins.adp & ~s.mode[BIT_LEARN];
    next_s.bat_sys = ~(pins.adp & ~s.mode[BIT_LEARN]);

    // Charging needs a good voltage and nonzero limits
    next_s.chg_en = !v_bad && (s.cvolt != RST_WORD)
                 && (s.ccur != RST_WORD) && (s.icur != RST_WORD);

    // Status content from the block's own state
    next_s.status              = RST_WORD;
    next_s.status[BIT_ADP_SYS] = s.adp_sys;
    next_s.status[BIT_BAT_SYS] = s.bat_sys;
    next_s.status[BIT_VRANGE]  = v_bad;
    stat_chg = (next_s.status != s.status);

    // A change wins over a clear in the same cycle
    if (stat_chg) begin
      next_s.alert_oe_n = 1'b0;
    end else if (rd_clr) begin
      next_s.alert_oe_n = 1'b1;
    end
  end

  // ==========================================================
  // State register; settings never time out
  // ==========================================================
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '{st: ST_IDLE, aft: ST_IDLE, sh: RST_BYTE, cnt: RST_CNT,
             rw: 1'b0, cmd: RST_BYTE, lo: RST_BYTE, bidx: 2'h0,
             tx: RST_WORD, sda_oe_n: 1'b1, alert_oe_n: 1'b1,
             mode: RST_WORD, ccur: RST_WORD,
             cvolt: RST_WORD,
             icur: RST_WORD, status: RST_STATUS, chg_en: 1'b0,
             adp_sys: 1'b0, bat_sys: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign o_sda                     = 1'b0;
  assign o_sda_oe_n                = s.sda_oe_n;
  assign o_alert                   = 1'b0;
  assign o_alert_oe_n              = s.alert_oe_n;
  assign o_charge_voltage_limit    = s.cvolt;
  assign o_charge_current_limit    = s.ccur;
  assign o_input_current_limit     = s.icur;
  assign o_mode_control            = s.mode;
  assign o_depleted_pack_threshold = s.mode[DEP_MSB:DEP_LSB];
  assign o_charge_en               = s.chg_en;
  assign o_adapter_to_sys          = s.adp_sys;
  assign o_battery_to_sys          = s.bat_sys;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence addr_done_s;
    s.st == ST_ADDR && !pins.start && !pins.stop && pins.scl_fall
      && s.cnt == BITS_PER_BYTE;
  endsequence

  sequence commit_s(logic [7:0] c);
    wr_commit && s.cmd == c && !pins.stop && !pins.start;
  endsequence

  addr_match_a: assert property (
    addr_done_s and (s.sh[7:1] != SLAVE_ADDR) |=> s.st == ST_IDLE && s.sda_oe_n)
    else $error("foreign address acknowledged");
  volt_write_a: assert property (
    commit_s(CMD_VOLT) |=> s.cvolt == $past(wword))
    else $error("charge voltage not written");
  curr_write_a: assert property (
    commit_s(CMD_CURR) |=> s.ccur == $past(wword))
    else $error("charge current not written");
  input_write_a: assert property (
    commit_s(CMD_INCURR) |=> s.icur == $past(wword))
    else $error("input current not written");
  mode_write_a: assert property (
    commit_s(CMD_MODE) |=> o_mode_control == $past(wword))
    else $error("mode not written");
  alert_set_a: assert property (
    stat_chg |=> !o_alert_oe_n ##1 !o_alert_oe_n || $past(rd_clr))
    else $error("status change without alert");
  alert_hold_a: assert property (
    !o_alert_oe_n && !rd_clr |=> !o_alert_oe_n)
    else $error("alert released without status read");
  alert_clear_a: assert property (
    rd_clr && !stat_chg |=> o_alert_oe_n)
    else $error("alert kept after status read");
  source_sel_a: assert property (
    pins.adp && !s.mode[BIT_LEARN] ##1 pins.adp && !s.mode[BIT_LEARN]
      |=> o_adapter_to_sys && !o_battery_to_sys)
    else $error("adapter not switched to system");
  volt_fault_a: assert property (
    v_bad |=> !o_charge_en && s.status[BIT_VRANGE] ##1 !o_charge_en || !$past(v_bad))
    else $error("bad voltage not flagged");

endmodule // csri_charger_regs

/* File: csri_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Bus master standing in for the host controller
// ==========================================================
module csri_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe_n
);
  initial begin
    o_scl      = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  // Six core cycles, half of the 48 ns bus clock
  task automatic half();
    repeat (6) @(posedge i_core_clk);
  endtask
  // Data moves one cycle after clock low, so never with a clock edge
  task automatic step(input logic b);
    @(posedge i_core_clk);
    o_sda_oe_n <= b;
    repeat (5) @(posedge i_core_clk);
    o_scl <= 1'b1;
    half();
  endtask
  // Start or repeated start
  task automatic start();
    step(1'b1);
    o_sda_oe_n <= 1'b0;
    half();
    o_scl <= 1'b0;
  endtask
  // Stop leaves both lines released high
  task automatic stop();
    step(1'b0);
    o_sda_oe_n <= 1'b1;
    half();
  endtask
  // Eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      step(d[i]);
      q[i] = i_sda;
      o_scl <= 1'b0;
    end
  endtask
  // Word write; acks holds address, command, low, high
  task automatic wr(input logic [7:0] adr, input logic [7:0] cmd,
                    input logic [15:0] d, output logic [3:0] acks);
    logic [8:0] q0, q1, q2, q3;
    start();
    xfer({adr, 1'b1}, q0);
    xfer({cmd, 1'b1}, q1);
    xfer({d[7:0], 1'b1}, q2);
    xfer({d[15:8], 1'b1}, q3);
    stop();
    acks = ~{q0[0], q1[0], q2[0], q3[0]};
  endtask
  // Word read, low byte acked, high byte refused
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    logic [8:0] q0, q1, q2, q3, q4;
    start();
    xfer({8'h12, 1'b1}, q0);
    xfer({cmd, 1'b1}, q1);
    start();
    xfer({8'h13, 1'b1}, q2);
    xfer(9'h1FE, q3);
    xfer(9'h1FF, q4);
    stop();
    d = {q4[8:1], q3[8:1]};
  endtask
endmodule // csri_host_model

/* File: csri_charger_regs_bench.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench of the charger register interface
// ==========================================================
module csri_charger_regs_bench;
  import csri_pkg::*;
  logic i_core_clk, i_rst_n, adp, scl, host_oe_n, sda_oe_n, alert_oe_n, sda_o, alert_o;
  logic chg_en, adp_sys, bat_sys;
  logic [15:0] volt, curr, incurr, mode, d;
  logic [2:0]  dep;
  logic [3:0]  acks;
  int          bad_count, samples_checked, cycles;
  wire logic   sda = host_oe_n & sda_oe_n;  // Pulled-up open drain
  csri_host_model host_u (.i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe_n(host_oe_n));
  csri_charger_regs dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda(sda), .o_sda(sda_o), .o_sda_oe_n(sda_oe_n), .i_alert(alert_oe_n),
    .o_alert(alert_o), .o_alert_oe_n(alert_oe_n), .i_adapter_det(adp),
    .o_charge_voltage_limit(volt), .o_charge_current_limit(curr),
    .o_input_current_limit(incurr), .o_mode_control(mode),
    .o_depleted_pack_threshold(dep), .o_charge_en(chg_en),
    .o_adapter_to_sys(adp_sys), .o_battery_to_sys(bat_sys));
  initial i_core_clk = 1'b0;
  always #2 i_core_clk = ~i_core_clk;
  // Hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Values after reset
  task automatic t_reset();
    check(volt, 16'h0000);
    check(16'(bat_sys), 16'h0001);
    check(16'(sda_o), 16'h0000);
    check(16'(alert_o), 16'h0000);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0040);
    wait_cyc(1);
    check(16'(alert_oe_n), 16'h0001);
  endtask
  // Every writable register, written and read back
  task automatic t_regs();
    logic [7:0]  c[4] = '{CMD_VOLT, CMD_CURR, CMD_INCURR, CMD_MODE};
    logic [15:0] v[4] = '{16'h2EE0, 16'h0080, 16'h0100, 16'h0A00};
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'h12, c[i], v[i], acks);
      check(16'(acks), 16'h000F);
      host_u.rd(c[i], d);
      check(d, v[i]);
    end
    wait_cyc(1);
    check(volt, 16'h2EE0);
    check(curr, 16'h0080);
    check(incurr, 16'h0100);
    check(mode, 16'h0A00);
    check(16'(dep), 16'h0005);
    check(16'(chg_en), 16'h0001);
  endtask
  // Foreign address, unknown command, read-only target
  task automatic t_refuse();
    host_u.wr(8'h14, CMD_VOLT, 16'h3A98, acks);
    check(16'(acks), 16'h0000);
    host_u.wr(8'h12, 8'h16, 16'h1234, acks);
    check(16'(acks[3:2]), 16'h0002);
    host_u.wr(8'h12, CMD_STATUS, 16'hFFFF, acks);
    wait_cyc(1);
    check(volt, 16'h2EE0);
    check(16'(alert_oe_n), 16'h0001);
  endtask
  // Voltage in the forbidden gap
  task automatic t_fault();
    host_u.wr(8'h12, CMD_VOLT, 16'h3A98, acks);
    wait_cyc(4);
    check(16'(chg_en), 16'h0000);
    check(16'(alert_oe_n), 16'h0000);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0050);
    wait_cyc(1);
    check(16'(alert_oe_n), 16'h0001);
    host_u.wr(8'h12, CMD_VOLT, 16'h2EE0, acks);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0040);
  endtask
  // Adapter arrival, calibration mode, adapter removal
  task automatic t_source();
    adp <= 1'b1;
    wait_cyc(20);
    check({adp_sys, bat_sys, alert_oe_n}, 16'h0004);
    wait_cyc(2000);
    check({chg_en, alert_oe_n}, 16'h0002);
    check(volt, 16'h2EE0);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0080);
    wait_cyc(1);
    check(16'(alert_oe_n), 16'h0001);
    host_u.wr(8'h12, CMD_MODE, 16'h0A40, acks);
    wait_cyc(20);
    check({adp_sys, bat_sys, alert_oe_n}, 16'h0002);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0040);
    host_u.wr(8'h12, CMD_MODE, 16'h0A00, acks);
    adp <= 1'b0;
    wait_cyc(20);
    check({adp_sys, bat_sys, alert_oe_n}, 16'h0002);
    host_u.rd(CMD_STATUS, d);
    check(d, 16'h0040);
  endtask
  initial begin
    i_rst_n = 1'b0;
    adp     = 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    wait_cyc(6);
    t_reset();
    t_regs();
    t_refuse();
    t_fault();
    t_source();
    end_of_test();
  end
endmodule // csri_charger_regs_bench
